/* File: pkg/acq_pkg.sv */
// Shared constants and carrier types for the acquisition and lead-off control bank
package acq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ACQ_CTRL_IDX = 8'h01;
  localparam logic [7:0] LEADOFF_CTRL_IDX = 8'h02;
  localparam logic [9:0] ACQ_CTRL_ADDR = {ACQ_CTRL_IDX, 2'b00};
  localparam logic [9:0] LEADOFF_CTRL_ADDR = {LEADOFF_CTRL_IDX, 2'b00};
  localparam int ADDR_DECODE_W = 10;

  // Acquisition control field positions
  localparam int SOFT_RESET_POS = 0;
  localparam int POWER_ON_POS = 1;
  localparam int CONVERSION_ON_POS = 2;
  localparam int RATE_SELECT_POS = 3;

  // Lead-off control field positions
  localparam int GLOBAL_AC_POS = 1;
  localparam int AC_ENABLE_LSB = 13;
  localparam int PHASE_LSB = 18;
  localparam int NUM_AC_ELECTRODES = 5;
  localparam int NUM_PHASE_ELECTRODES = 6;

  // Values after reset
  localparam logic [23:0] ACQ_CTRL_RESET = 24'h000000;
  localparam logic [23:0] LEADOFF_CTRL_RESET = 24'h000000;

  // Sampling rates and the cycle counts derived from the 40 MHz clock
  localparam int CLK_HZ = 40_000_000;
  localparam int LOW_RATE_SPS = 1_000_000;
  localparam int HIGH_RATE_SPS = 2_000_000;
  localparam logic [5:0] LOW_RATE_DIV = 6'(CLK_HZ / LOW_RATE_SPS);
  localparam logic [5:0] HIGH_RATE_DIV = 6'(CLK_HZ / HIGH_RATE_SPS);

  // AHB transfer encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Acquisition control contents
  typedef struct packed {
    logic rate_select;
    logic conversion_on;
    logic power_on;
  } acq_ctrl_t;

  // Lead-off control contents (phase: left arm at msb down to common electrode)
  typedef struct packed {
    logic [NUM_PHASE_ELECTRODES-1:0] phase;
    logic [NUM_AC_ELECTRODES-1:0] ac_enable;
    logic global_ac_select;
  } leadoff_ctrl_t;

  // Pending bus write captured in the address phase
  typedef struct packed {
    logic valid;
    logic [ADDR_DECODE_W-1:0] addr;
  } bus_wr_t;

endpackage

/* File: rtl/acq_power_and_leadoff_ctrl.sv */
// Acquisition and lead-off control register bank with AHB-Lite slave
//
// Behaviour
// - rate bit picks 1 or 2 MSPS
// - conversion bit runs converter and filters while power bit is set
// - power bit off powers analog and oscillator down
// - registers keep values while powered down
// - writing one to reset restores all registers
// - reset bit clears itself
// - lead-off register at index two, resets zero
// - bits 23..18 set per-electrode excitation phase
// - bits 17..13 ORed with global select
// - global select enables all but common electrode
// - rate bit sits at bit three
module acq_power_and_leadoff_ctrl (
  input wire logic hclk, // System clock, 40 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data, registered
  output logic analog_power_on, // Analog blocks powered
  output logic osc_enable, // Crystal oscillator enable
  output logic high_rate, // Fast sampling selected
  output logic filter_enable, // Digital filters running
  output logic sample_tick, // One-cycle conversion strobe
  output logic [acq_pkg::NUM_AC_ELECTRODES-1:0] ac_leadoff_on, // Effective ac enables
  output logic [acq_pkg::NUM_PHASE_ELECTRODES-1:0] ac_leadoff_phase // Excitation phases
);

  acq_pkg::acq_ctrl_t acq_ff;
  acq_pkg::leadoff_ctrl_t loff_ff;
  acq_pkg::bus_wr_t wr_ff;
  logic soft_reset_bit_ff;
  logic addr_phase;
  logic wr_acq;
  logic wr_loff;
  logic soft_req;
  logic conv_active;
  logic [23:0] acq_word;
  logic [23:0] loff_word;
  logic [31:0] nxt_hrdata;
  logic [acq_pkg::ADDR_DECODE_W-1:0] dec_addr;

  // Zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // An accepted address phase; only whole-word singles are expected
  assign addr_phase = hsel && hready && (htrans == acq_pkg::HTRANS_NONSEQ ||
                      htrans == acq_pkg::HTRANS_SEQ);
  assign dec_addr = haddr[acq_pkg::ADDR_DECODE_W-1:0];

  // Capture write address so the data phase knows its target
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ff <= '0;
    else if (hready)
    begin
      wr_ff.valid <= addr_phase && hwrite && hsize == 3'h2;
      wr_ff.addr <= dec_addr;
    end
  end

  // Data-phase decode; unmapped addresses simply do nothing
  assign wr_acq = wr_ff.valid && wr_ff.addr == acq_pkg::ACQ_CTRL_ADDR;
  assign wr_loff = wr_ff.valid && wr_ff.addr == acq_pkg::LEADOFF_CTRL_ADDR;
  assign soft_req = wr_acq && hwdata[acq_pkg::SOFT_RESET_POS];

  // Acquisition control; no clock gating on power-down so the contents stay put
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acq_ff <= '0;
    else if (soft_req)
      acq_ff <= '0;
    else if (wr_acq)
    begin
      acq_ff.rate_select <= hwdata[acq_pkg::RATE_SELECT_POS];
      acq_ff.conversion_on <= hwdata[acq_pkg::CONVERSION_ON_POS];
      acq_ff.power_on <= hwdata[acq_pkg::POWER_ON_POS];
    end
  end

  // Lead-off control; a soft reset outranks a write in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loff_ff <= '0;
    else if (soft_req)
      loff_ff <= '0;
    else if (wr_loff)
    begin
      loff_ff.phase <= hwdata[23:acq_pkg::PHASE_LSB];
      loff_ff.ac_enable <= hwdata[17:acq_pkg::AC_ENABLE_LSB];
      loff_ff.global_ac_select <= hwdata[acq_pkg::GLOBAL_AC_POS];
    end
  end

  // Reset bit reads one until the next accepted transfer finishes the reset;
  // a new reset request wins over that completion in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      soft_reset_bit_ff <= 1'b0;
    else if (soft_req)
      soft_reset_bit_ff <= 1'b1;
    else if (addr_phase)
      soft_reset_bit_ff <= 1'b0;
  end

  // Register images as software sees them; unused bits read zero
  always_comb
  begin
    acq_word = acq_pkg::ACQ_CTRL_RESET;
    acq_word[acq_pkg::RATE_SELECT_POS] = acq_ff.rate_select;
    acq_word[acq_pkg::CONVERSION_ON_POS] = acq_ff.conversion_on;
    acq_word[acq_pkg::POWER_ON_POS] = acq_ff.power_on;
    acq_word[acq_pkg::SOFT_RESET_POS] = soft_reset_bit_ff;
    loff_word = acq_pkg::LEADOFF_CTRL_RESET;
    loff_word[23:acq_pkg::PHASE_LSB] = loff_ff.phase;
    loff_word[17:acq_pkg::AC_ENABLE_LSB] = loff_ff.ac_enable;
    loff_word[acq_pkg::GLOBAL_AC_POS] = loff_ff.global_ac_select;
  end

  // Read mux in the address phase, so data stands in the following data phase
  always_comb
  begin
    nxt_hrdata = 32'h00000000;
    if (addr_phase && !hwrite)
    begin
      case (dec_addr)
        acq_pkg::ACQ_CTRL_ADDR: nxt_hrdata = {8'h00, acq_word};
        acq_pkg::LEADOFF_CTRL_ADDR: nxt_hrdata = {8'h00, loff_word};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready)
      hrdata <= nxt_hrdata;
  end

  // Conversions need both power and conversion enable
  assign conv_active = acq_ff.power_on && acq_ff.conversion_on;

  // Power and rate drive flops, so outputs change one cycle after the register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      analog_power_on <= 1'b0;
      osc_enable <= 1'b0;
      high_rate <= 1'b0;
      filter_enable <= 1'b0;
    end
    else
    begin
      analog_power_on <= acq_ff.power_on;
      osc_enable <= acq_ff.power_on;
      high_rate <= acq_ff.rate_select;
      filter_enable <= conv_active;
    end
  end

  // Sampling strobe at the chosen rate
  sample_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(conv_active),
    .rate_select(acq_ff.rate_select),
    .tick(sample_tick)
  );

  // Per-electrode lead-off drive
  leadoff_combiner u_loff (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctrl(loff_ff),
    .ac_active(ac_leadoff_on),
    .phase_out(ac_leadoff_phase)
  );

  // Helper: cycles since the last strobe, restarted whenever the rate or run changes
  logic [6:0] gap_ff;
  logic seen_ff;
  logic rate_d_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_ff <= 7'h00;
      seen_ff <= 1'b0;
      rate_d_ff <= 1'b0;
    end
    else
    begin
      rate_d_ff <= acq_ff.rate_select;
      if (!conv_active || rate_d_ff != acq_ff.rate_select)
      begin
        gap_ff <= 7'h00;
        seen_ff <= 1'b0;
      end
      else if (sample_tick)
      begin
        gap_ff <= 7'h01;
        seen_ff <= 1'b1;
      end
      else if (gap_ff != 7'h7f)
        gap_ff <= gap_ff + 7'h01;
    end
  end

  // Strobe spacing matches the rate the divider used when it launched the strobe
  a_tick_rate_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick && seen_ff |->
      gap_ff == {1'b0, ($past(acq_ff.rate_select) ? acq_pkg::HIGH_RATE_DIV :
      acq_pkg::LOW_RATE_DIV)})
    else $error("sample strobe spacing wrong for rate");

  // No strobe without power and conversion enable in the cycle before
  a_tick_needs_power: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick |-> $past(conv_active))
    else $error("sample strobe while powered down or idle");

  // Filters follow the conversion and power bits one cycle later
  a_filter_follows_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 filter_enable == $past(acq_ff.conversion_on && acq_ff.power_on))
    else $error("filter enable does not follow conversion bit");

  // Clearing power turns analog and oscillator off next cycle
  a_power_down_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
    !acq_ff.power_on |=> !analog_power_on && !osc_enable)
    else $error("analog or oscillator left on after power down");

  // Without a write, register contents hold through power-down
  a_power_retains_regs: assert property (@(posedge hclk) disable iff (!hresetn)
    !acq_ff.power_on && !wr_ff.valid |=> $stable(loff_ff) && $stable(acq_ff))
    else $error("register changed during power down");

  // A soft reset write returns both registers to zero and raises the bit
  a_soft_reset_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_req |=> acq_ff == '0 && loff_ff == '0 && soft_reset_bit_ff)
    else $error("soft reset did not restore registers");

  // The reset bit drops at the first transfer after its set cycle
  a_soft_self_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset_bit_ff && addr_phase && !soft_req |=> !soft_reset_bit_ff)
    else $error("soft reset bit did not clear itself");

  // Writing zero to the reset bit keeps the power bit as written
  a_zero_no_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_acq && !hwdata[acq_pkg::SOFT_RESET_POS] |=>
      acq_ff.power_on == $past(hwdata[acq_pkg::POWER_ON_POS]) && !soft_reset_bit_ff ||
      $past(soft_reset_bit_ff) && !$past(addr_phase))
    else $error("writing zero to reset bit changed behaviour");

  // Global select lights every non-common enable one cycle later
  a_global_enables_all: assert property (@(posedge hclk) disable iff (!hresetn)
    loff_ff.global_ac_select |=> &ac_leadoff_on)
    else $error("global select did not enable all electrodes");

  // Each effective enable is own bit OR global select
  a_ac_enable_or: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ac_leadoff_on == ($past(loff_ff.ac_enable) |
      {acq_pkg::NUM_AC_ELECTRODES{$past(loff_ff.global_ac_select)}}))
    else $error("ac enable is not the OR of its sources");

  // Phase outputs track the register bits
  a_phase_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ac_leadoff_phase == $past(loff_ff.phase))
    else $error("phase output does not track register");

  // Lead-off register reads back at its address with the fields in place
  a_loff_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && dec_addr == acq_pkg::LEADOFF_CTRL_ADDR |=>
      hrdata == {8'h00, $past(loff_word)})
    else $error("lead-off readback mismatch");

  // Rate output follows the rate bit in bit three
  a_rate_bit_three: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_acq && !soft_req |=> ##1 high_rate == $past(hwdata[acq_pkg::RATE_SELECT_POS], 2))
    else $error("rate output not taken from bit three");

endmodule

/* File: rtl/leadoff_combiner.sv */
// Per-electrode ac lead-off enable and phase drive, registered
module leadoff_combiner (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input acq_pkg::leadoff_ctrl_t ctrl, // Lead-off control contents
  output logic [acq_pkg::NUM_AC_ELECTRODES-1:0] ac_active, // Effective ac enables
  output logic [acq_pkg::NUM_PHASE_ELECTRODES-1:0] phase_out // Excitation phase
);

  genvar i;

  // Global select reaches only the five limb and chest electrodes, never common
  generate
    for (i = 0; i < acq_pkg::NUM_AC_ELECTRODES; i++)
    begin : g_ac
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          ac_active[i] <= 1'b0;
        else
          ac_active[i] <= ctrl.ac_enable[i] | ctrl.global_ac_select;
      end
    end
  endgenerate

  // Phase bits go straight out, one flop each
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_out <= '0;
    else
      phase_out <= ctrl.phase;
  end

endmodule

/* File: rtl/sample_divider.sv */
// Conversion strobe divider: one-cycle pulse at the selected sampling rate
module sample_divider (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic run, // Conversion allowed
  input wire logic rate_select, // 1 selects the fast rate
  output logic tick // One-cycle sample strobe
);

  logic [5:0] count_ff;
  logic rate_ff;
  logic [5:0] div_len;

  // Period in cycles for the current rate
  assign div_len = rate_select ? acq_pkg::HIGH_RATE_DIV : acq_pkg::LOW_RATE_DIV;

  // Restart on stop or rate change so the first period is always whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_ff <= 6'h00;
      rate_ff <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      rate_ff <= rate_select;
      if (!run || rate_ff != rate_select)
      begin
        count_ff <= 6'h00;
        tick <= 1'b0;
      end
      else if (count_ff == div_len - 6'h01)
      begin
        count_ff <= 6'h00;
        tick <= 1'b1;
      end
      else
      begin
        count_ff <= count_ff + 6'h01;
        tick <= 1'b0;
      end
    end
  end

endmodule

/* File: testbench/acq_power_and_leadoff_ctrl_test.sv */
// Self-checking bench for the acquisition and lead-off control bank
module acq_power_and_leadoff_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ACQ = 32'(acq_pkg::ACQ_CTRL_ADDR);
  localparam logic [31:0] LOFF = 32'(acq_pkg::LEADOFF_CTRL_ADDR);
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic analog_power_on;
  logic osc_enable;
  logic high_rate;
  logic filter_enable;
  logic sample_tick;
  logic [4:0] ac_on;
  logic [5:0] ac_ph;
  logic [31:0] v;
  logic late;
  int n;
  int fails = 0;
  int checks = 0;

  // 40 MHz system clock
  always #12.5 hclk = ~hclk;

  ahb_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  acq_power_and_leadoff_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .analog_power_on(analog_power_on), .osc_enable(osc_enable), .high_rate(high_rate),
    .filter_enable(filter_enable), .sample_tick(sample_tick), .ac_leadoff_on(ac_on),
    .ac_leadoff_phase(ac_ph));

  // Closing report, also reached when a wait runs out
  task automatic results();
    begin
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        fails++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    begin
      host.xfer(a, 1'b1, d, r, late);
      if (late)
      begin
        fails++;
        results();
      end
    end
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    begin
      host.xfer(a, 1'b0, 32'h00000000, d, late);
      if (late)
      begin
        fails++;
        results();
      end
    end
  endtask

  // Registered outputs trail the register by one cycle; look well after the edge
  task automatic settle();
    begin
      repeat (2) @(posedge hclk);
      #1;
    end
  endtask

  // Cycles between two strobes; every cycle is looked at, since the strobe lasts one
  task automatic period(output int p);
    begin
      p = 0;
      while (sample_tick !== 1'b1 && p < 200)
      begin
        p++;
        @(posedge hclk);
        #1;
      end
      if (p >= 200)
      begin
        fails++;
        results();
      end
      p = 1;
      @(posedge hclk);
      #1;
      while (sample_tick !== 1'b1 && p < 200)
      begin
        p++;
        @(posedge hclk);
        #1;
      end
      if (p >= 200)
      begin
        fails++;
        results();
      end
    end
  endtask

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ACQ, v);
    check(v, 32'h00000000);
    rd(LOFF, v);
    check(v, 32'h00000000);
    rd(32'h0000000c, v);
    check(v, 32'h00000000);
    check(32'({analog_power_on, osc_enable, filter_enable, sample_tick}), 32'h0);
    check(32'({hreadyout, hresp}), 32'h00000002);
    $display("test reset done");
    wr(LOFF, 32'hffffffff);
    rd(LOFF, v);
    check(v, 32'h00ffe002);
    settle();
    check(32'(ac_ph), 32'h0000003f);
    check(32'(ac_on), 32'h0000001f);
    // Each enable alone, then global select alone; common electrode has no enable
    for (int i = 0; i < 5; i++)
    begin
      wr(LOFF, 32'(1) << (13 + i));
      settle();
      check(32'(ac_on), 32'(1) << i);
    end
    wr(LOFF, 32'h00000002);
    settle();
    check(32'(ac_on), 32'h0000001f);
    for (int j = 0; j < 6; j++)
    begin
      wr(LOFF, 32'(1) << (18 + j));
      settle();
      check(32'(ac_ph), 32'(1) << j);
    end
    wr(LOFF, 32'h00842002);
    $display("test leadoff done");
    wr(ACQ, 32'h00000002);
    settle();
    check(32'({analog_power_on, osc_enable, filter_enable}), 32'h6);
    wr(ACQ, 32'h00000006);
    settle();
    check(32'(filter_enable), 32'h1);
    check(32'(high_rate), 32'h0);
    period(n);
    check(32'(n), 32'h00000028);
    wr(ACQ, 32'h0000000e);
    settle();
    check(32'(high_rate), 32'h1);
    period(n);
    check(32'(n), 32'h00000014);
    // Power off with conversion still requested
    wr(ACQ, 32'h0000000c);
    settle();
    check(32'({analog_power_on, osc_enable, filter_enable}), 32'h0);
    n = 0;
    repeat (100)
    begin
      @(posedge hclk);
      #1;
      if (sample_tick === 1'b1)
        n++;
    end
    check(32'(n), 32'h00000000);
    rd(ACQ, v);
    check(v, 32'h0000000c);
    rd(LOFF, v);
    check(v, 32'h00842002);
    $display("test power done");
    host.soft_reset(late);
    if (late)
    begin
      fails++;
      results();
    end
    rd(ACQ, v);
    check(v, 32'h00000000);
    rd(LOFF, v);
    check(v, 32'h00000000);
    settle();
    check(32'({ac_on, ac_ph, high_rate}), 32'h0);
    $display("test soft reset done");
    results();
  end
endmodule

/* File: testbench/ahb_host_model.sv */
// Host processor model: AHB-Lite master issuing single word transfers
module ahb_host_model (
  input wire logic hclk, // System clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Slave select
  output logic [31:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write when high
  output logic [2:0] hsize, // Word size
  output logic [31:0] hwdata // Write data
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 50;

  // Idle bus at time zero; the one slave stays selected, htrans keeps it quiet
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // One transfer, entered just after an edge; released lines show inverted values
  // so the slave cannot lean on a stale bus
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd, output logic late);
    int n;
    begin
      n = 0;
      haddr <= a;
      hwrite <= w;
      htrans <= acq_pkg::HTRANS_NONSEQ;
      @(posedge hclk);
      while (hready !== 1'b1 && n < LIMIT)
      begin
        n++;
        @(posedge hclk);
      end
      htrans <= 2'h0;
      haddr <= ~a;
      hwrite <= ~w;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1 && n < LIMIT)
      begin
        n++;
        @(posedge hclk);
      end
      rd = hrdata;
      hwdata <= ~wd;
      late = (n >= LIMIT);
    end
  endtask

  // Self-clearing reset, then the no-op access that lets it finish
  task automatic soft_reset(output logic late);
    logic [31:0] r;
    logic l1;
    begin
      xfer(32'(acq_pkg::ACQ_CTRL_ADDR), 1'b1, 32'h00000001, r, l1);
      xfer(32'(acq_pkg::ACQ_CTRL_ADDR), 1'b0, 32'h00000000, r, late);
      late = late | l1;
    end
  endtask
endmodule
